// >>> logic/tbe_map.svh
`ifndef TBE_MAP_SVH
`define TBE_MAP_SVH
// timing
`define TBE_CLK_NS      10
`define TBE_PROG_NS     1000000
// sizes
`define TBE_NREC        12
`define TBE_NFUNC       8
`define TBE_NEVT        28
`define TBE_NARC        26
// event ids of the common outputs
`define TBE_ID_CSTART   26
`define TBE_ID_CTRIP    27
// byte offsets
`define TBE_OFS_CTRL    8'h00
`define TBE_OFS_FUNCEN  8'h04
`define TBE_OFS_ONMASK  8'h08
`define TBE_OFS_OFFMASK 8'h0c
`define TBE_OFS_STATUS  8'h10
`define TBE_OFS_ARCCNT  8'h14
`define TBE_OFS_STCNT   8'h18
`define TBE_OFS_TRCNT   8'h1c
`define TBE_OFS_TIME    8'h20
`define TBE_OFS_RECSEL  8'h24
`define TBE_OFS_RECTIME 8'h28
`define TBE_OFS_RECEVT  8'h2c
`define TBE_OFS_RECAB   8'h30
`define TBE_OFS_RECCR   8'h34
// field positions
`define TBE_CTRL_CLR    0
`define TBE_CTRL_FRC    1
// reset values
`define TBE_FUNCEN_RST  8'hff
`define TBE_MASK_RST    28'hfffffff
`endif

// >>> logic/tbe_pkg.sv
`include "tbe_map.svh"
package tbe_pkg;
   // gray along normal -> start -> trip
   typedef enum logic [1:0] {
      COND_NORMAL = 2'h0,
      COND_START  = 2'h1,
      COND_TRIP   = 2'h3
   } tbe_cond_e;

   typedef struct packed {
      logic [31:0] ts;
      logic [5:0]  code;
      logic [15:0] ia;
      logic [15:0] ib;
      logic [15:0] ic;
      logic [15:0] i0;
      logic [3:0]  sens;
      logic [2:0]  sg;
   } tbe_rec_s;

   typedef struct packed {
      logic [108:0]                   s1;
      logic [108:0]                   s2;
      logic [16:0]                    div;
      logic                           blkSmp;
      logic [3:0]                     pickPrev;
      logic [3:0]                     zoneTrip;
      logic [3:0]                     zoneBlk;
      logic                           comStart;
      logic                           comTrip;
      tbe_cond_e                      cond;
      logic [`TBE_NEVT-1:0]           prev;
      logic [`TBE_NEVT-1:0]           pendOn;
      logic [`TBE_NEVT-1:0]           pendOff;
      logic [`TBE_NEVT-1:0]           onMask;
      logic [`TBE_NEVT-1:0]           offMask;
      logic                           evtValid;
      logic [5:0]                     evtCode;
      logic [31:0]                    evtTime;
      logic [31:0]                    ts;
      logic [31:0]                    arcCnt;
      logic [31:0]                    startCnt;
      logic [31:0]                    tripCnt;
      logic [`TBE_NFUNC-1:0]          funcEn;
      tbe_cond_e                      forceSel;
      tbe_rec_s [`TBE_NREC-1:0]       rec;
      logic [3:0]                     wrPtr;
      logic [3:0]                     recCnt;
      logic [3:0]                     recSel;
      logic                           pready;
      logic                           pslverr;
      logic [31:0]                    prdata;
   } tbe_state_s;
endpackage

// >>> logic/tbe_trip_event.sv
// Operation
// - blocking input sampled once at each program cycle start, used for its decisions
// - pick-up rising with sampled block inactive asserts the zone trip output
// - pick-up rising with block active gives blocked indication, no further handling
// - per event, software selects ON, OFF or both into the event stream
// - each emitted event carries the time stamp of its occurrence
// - arc stage reports zone, current, light, pressure, input and fault changes
// - arc stage event counter increments per event, clearable by software
// - twelve newest operation records kept, oldest overwritten
// - record holds ms time, event, three phase currents, residual, sensors, group
// - common start/trip is the OR of enabled function starts/trips
// - two extra inputs are ORed into common start and common trip
// - common outputs forceable to normal, start or trip only when forcing enabled
// - aggregator condition reported as normal, start or trip
// - aggregator has no blocking input of its own
// - common start and common trip changes produce ON and OFF events
// - resettable counters of common start and common trip events
// - aggregator settings are static, unaffected by the setting group
//
// The register offsets and the APB register port were chosen for this implementation.
`include "tbe_map.svh"
module tbe_trip_event #(
   parameter int unsigned PROG_CYCLES = `TBE_PROG_NS / `TBE_CLK_NS
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        blockIn,
   input  wire logic [3:0]  pickUp,
   input  wire logic        phStartIn,
   input  wire logic        phBlkIn,
   input  wire logic        resStartIn,
   input  wire logic        resBlkIn,
   input  wire logic [3:0]  lightIn,
   input  wire logic [3:0]  pressIn,
   input  wire logic        digitalInput,
   input  wire logic [3:0]  sensFault,
   input  wire logic        ioFault,
   input  wire logic [7:0]  funcStart,
   input  wire logic [7:0]  funcTrip,
   input  wire logic        extraStart,
   input  wire logic        extraTrip,
   input  wire logic        forceEnable,
   input  wire logic [2:0]  settingGroup,
   input  wire logic [15:0] phA,
   input  wire logic [15:0] phB,
   input  wire logic [15:0] phC,
   input  wire logic [15:0] resCur,
   output logic      [3:0]  zoneTrip,
   output logic      [3:0]  zoneBlocked,
   output logic             comStart,
   output logic             comTrip,
   output logic      [1:0]  condition,
   output logic             evtValid,
   output logic      [5:0]  evtCode,
   output logic      [31:0] evtTime
);
   tbe_pkg::tbe_state_s r;
   tbe_pkg::tbe_state_s n;
   logic [108:0] syncIn;
   logic         bk;
   logic [3:0]   pk;
   logic [7:0]   fs;
   logic [7:0]   ft;
   logic         xs;
   logic         xt;
   logic         fe;
   logic         tick;
   logic         clrW;
   logic [3:0]   lt;
   logic [3:0]   pr;
   logic [3:0]   sf;

   // all pins except clock, reset and the APB port pass the two-stage synchroniser
   assign syncIn = {settingGroup, resCur, phC, phB, phA, forceEnable, extraTrip,
                    extraStart, funcTrip, funcStart, ioFault, sensFault, digitalInput,
                    pressIn, lightIn, resBlkIn, resStartIn, phBlkIn, phStartIn,
                    pickUp, blockIn};
   // s2 layout, lsb first: block 0, pick-up 4:1, current statuses 8:5, light 12:9,
   // pressure 16:13, input 17, sensor fault 21:18, unit fault 22, starts 30:23,
   // trips 38:31, extras 40:39, forcing 41, currents 105:42, group 108:106
   assign bk   = r.s2[0];
   assign pk   = r.s2[4:1];
   assign lt   = r.s2[12:9];
   assign pr   = r.s2[16:13];
   assign sf   = r.s2[21:18];
   assign fs   = r.s2[30:23];
   assign ft   = r.s2[38:31];
   assign xs   = r.s2[39];
   assign xt   = r.s2[40];
   assign fe   = r.s2[41];
   assign tick = (r.div == 17'(PROG_CYCLES - 1));
   assign clrW = psel && penable && r.pready && pwrite
                 && (paddr == `TBE_OFS_CTRL) && pwdata[`TBE_CTRL_CLR];

   // lowest set bit of an event vector
   function automatic logic [4:0] firstSet(input logic [`TBE_NEVT-1:0] v);
      logic [4:0] id;
      id = 5'h0;
      for (int i = `TBE_NEVT - 1; i >= 0; i--) begin
         if (v[i]) begin
            id = 5'(i);
         end
      end
      return id;
   endfunction

   // slot of the record sel steps back from the newest
   function automatic logic [3:0] recIdx(input logic [3:0] wp, input logic [3:0] sel);
      int k;
      k = (int'(wp) + 2 * `TBE_NREC - 1 - int'(sel)) % `TBE_NREC;
      return 4'(k);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `TBE_OFS_RECCR);
   endfunction

   // next state: bus, program cycle, events
   always_comb begin
      logic [`TBE_NEVT-1:0] stat;
      logic [`TBE_NEVT-1:0] rise;
      logic [`TBE_NEVT-1:0] fall;
      logic                 st;
      logic                 tr;
      logic [4:0]           id;
      logic [3:0]           ri;
      tbe_pkg::tbe_rec_s    sr;
      stat = '0;
      rise = '0;
      fall = '0;
      st = 1'b0;
      tr = 1'b0;
      id = 5'h0;
      ri = recIdx(r.wrPtr, r.recSel);
      sr = r.rec[ri];
      n = r;
      n.s1 = syncIn;
      n.s2 = r.s1;
      n.evtValid = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.div = tick ? 17'h0 : r.div + 17'h1;

      // apb: answer one cycle into the access phase, act on the sampled edge
      if (psel && penable && !r.pready) begin
         n.pready = 1'b1;
         n.pslverr = !mapped(paddr);
         n.prdata = 32'h0;
         if (!pwrite) begin
            unique case (paddr)
               `TBE_OFS_CTRL:    n.prdata = {29'h0, r.forceSel, 1'b0};
               `TBE_OFS_FUNCEN:  n.prdata = {24'h0, r.funcEn};
               `TBE_OFS_ONMASK:  n.prdata = {4'h0, r.onMask};
               `TBE_OFS_OFFMASK: n.prdata = {4'h0, r.offMask};
               `TBE_OFS_STATUS:  n.prdata = {16'h0, r.recCnt, r.zoneBlk, r.zoneTrip,
                                             1'b0, r.blkSmp, r.cond};
               `TBE_OFS_ARCCNT:  n.prdata = r.arcCnt;
               `TBE_OFS_STCNT:   n.prdata = r.startCnt;
               `TBE_OFS_TRCNT:   n.prdata = r.tripCnt;
               `TBE_OFS_TIME:    n.prdata = r.ts;
               `TBE_OFS_RECSEL:  n.prdata = {28'h0, r.recSel};
               `TBE_OFS_RECTIME: n.prdata = (r.recSel < r.recCnt) ? sr.ts : 32'h0;
               `TBE_OFS_RECEVT:  n.prdata = (r.recSel < r.recCnt) ?
                                            {19'h0, sr.sg, sr.sens, sr.code} : 32'h0;
               `TBE_OFS_RECAB:   n.prdata = (r.recSel < r.recCnt) ? {sr.ib, sr.ia} : 32'h0;
               `TBE_OFS_RECCR:   n.prdata = (r.recSel < r.recCnt) ? {sr.i0, sr.ic} : 32'h0;
               default:          n.prdata = 32'h0;
            endcase
         end
      end else if (psel && penable && pwrite) begin
         unique case (paddr)
            `TBE_OFS_CTRL: begin
               // force choice stored, applied only with forcing enabled
               n.forceSel = tbe_pkg::tbe_cond_e'(pwdata[`TBE_CTRL_FRC+:2]);
               // clear request; later increments still win
               if (pwdata[`TBE_CTRL_CLR]) begin
                  n.arcCnt = 32'h0;
                  n.startCnt = 32'h0;
                  n.tripCnt = 32'h0;
               end
            end
            `TBE_OFS_FUNCEN:  n.funcEn = pwdata[`TBE_NFUNC-1:0];
            `TBE_OFS_ONMASK:  n.onMask = pwdata[`TBE_NEVT-1:0];
            `TBE_OFS_OFFMASK: n.offMask = pwdata[`TBE_NEVT-1:0];
            `TBE_OFS_TIME:    n.ts = pwdata;
            `TBE_OFS_RECSEL:  n.recSel = pwdata[3:0];
            default:          n.recSel = n.recSel;
         endcase
      end

      // drain one pending event per clock, ON before OFF
      if (|r.pendOn || |r.pendOff) begin
         id = |r.pendOn ? firstSet(r.pendOn) : firstSet(r.pendOff);
         if (|r.pendOn) begin
            n.pendOn[id] = 1'b0;
         end else begin
            n.pendOff[id] = 1'b0;
         end
         // stamped with the current ms time
         n.evtValid = 1'b1;
         n.evtCode = {|r.pendOn, id};
         n.evtTime = r.ts;
         if (id < 5'(`TBE_NARC)) begin
            n.arcCnt = n.arcCnt + 32'h1;
         end
      end

      if (tick) begin
         n.ts = n.ts + 32'h1;
         n.blkSmp = bk;
         n.pickPrev = pk;
         for (int z = 0; z < 4; z++) begin
            if (!pk[z]) begin
               n.zoneTrip[z] = 1'b0;
               n.zoneBlk[z] = 1'b0;
            end else if (!r.pickPrev[z]) begin
               // blocked pick-up latched until it drops
               n.zoneBlk[z] = bk;
               n.zoneTrip[z] = !bk;
            end
         end
         st = |(fs & r.funcEn) || xs;
         tr = |(ft & r.funcEn) || xt;
         if (fe && r.forceSel == tbe_pkg::COND_START) begin
            st = 1'b1;
            tr = 1'b0;
         end else if (fe && r.forceSel == tbe_pkg::COND_TRIP) begin
            st = 1'b1;
            tr = 1'b1;
         end else if (fe && r.forceSel == tbe_pkg::COND_NORMAL) begin
            st = 1'b0;
            tr = 1'b0;
         end
         n.comStart = st;
         n.comTrip = tr;
         n.cond = tr ? tbe_pkg::COND_TRIP : st ? tbe_pkg::COND_START : tbe_pkg::COND_NORMAL;
         // counts of rising start and trip
         if (st && !r.comStart) begin
            n.startCnt = n.startCnt + 32'h1;
         end
         if (tr && !r.comTrip) begin
            n.tripCnt = n.tripCnt + 32'h1;
         end
         stat = {tr, st, r.s2[22], sf, r.s2[17], pr, lt,
                 r.s2[8], r.s2[7], r.s2[6], r.s2[5], n.zoneBlk, n.zoneTrip};
         // edges compared once per program cycle
         rise = stat & ~r.prev;
         fall = ~stat & r.prev;
         n.prev = stat;
         // masked into pending, set wins over drain
         n.pendOn = n.pendOn | (rise & r.onMask);
         n.pendOff = n.pendOff | (fall & r.offMask);
         // setting group only recorded, never steers settings
         if (|rise[7:0]) begin
            n.rec[r.wrPtr] = {n.ts, {1'b1, firstSet({20'h0, rise[7:0]})},
                              r.s2[57:42], r.s2[73:58], r.s2[89:74], r.s2[105:90],
                              lt, r.s2[108:106]};
            n.wrPtr = (r.wrPtr == 4'(`TBE_NREC - 1)) ? 4'h0 : r.wrPtr + 4'h1;
            if (r.recCnt < 4'(`TBE_NREC)) begin
               n.recCnt = r.recCnt + 4'h1;
            end
         end
      end
   end

   // state register, constant reset values only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.funcEn <= `TBE_FUNCEN_RST;
         r.onMask <= `TBE_MASK_RST;
         r.offMask <= `TBE_MASK_RST;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign zoneTrip = r.zoneTrip;
   assign zoneBlocked = r.zoneBlk;
   assign comStart = r.comStart;
   assign comTrip = r.comTrip;
   assign condition = r.cond;
   assign evtValid = r.evtValid;
   assign evtCode = r.evtCode;
   assign evtTime = r.evtTime;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_blk_sample: assert property (tick |=> r.blkSmp == $past(bk))
      else $error("block not sampled at cycle start");
   a_trip_free: assert property (tick && pk[0] && !r.pickPrev[0] && !bk
      |=> r.zoneTrip[0] && !r.zoneBlk[0]) else $error("unblocked pick-up did not trip");
   a_block_hold: assert property (tick && pk[1] && !r.pickPrev[1] && bk
      |=> !r.zoneTrip[1] ##1 (r.zoneBlk[1] && !r.zoneTrip[1]) [*3])
      else $error("blocked pick-up tripped");
   a_evt_stamp: assert property (r.evtValid |-> r.evtTime == $past(r.ts))
      else $error("event stamp wrong");
   a_start_evt: assert property ($rose(r.comStart) && r.onMask[`TBE_ID_CSTART]
      |-> ##[0:40] (r.evtValid && r.evtCode == 6'h3a)) else $error("start ON event missing");
   a_start_cnt: assert property ($rose(r.comStart) && !$past(clrW)
      |-> r.startCnt == $past(r.startCnt) + 32'h1) else $error("start count wrong");
   a_agg_or: assert property (tick && !fe && |(fs & r.funcEn)
      |=> r.comStart && r.cond != tbe_pkg::COND_NORMAL) else $error("common start missing");
   a_extra_trip: assert property (tick && !fe && xt |=> r.comTrip)
      else $error("extra trip ignored");
   a_force_trip: assert property (tick && fe && r.forceSel == tbe_pkg::COND_TRIP
      |=> r.comTrip && r.cond == tbe_pkg::COND_TRIP) else $error("forced trip not applied");
   a_rec_bound: assert property (r.recCnt <= 4'(`TBE_NREC) && r.wrPtr < 4'(`TBE_NREC))
      else $error("record ring out of range");
   a_apb_answer: assert property (psel && penable && !r.pready |=> r.pready)
      else $error("apb answer late");

   c_zone_trip: cover property (tick && pk[0] && !r.pickPrev[0] && !bk);
   c_zone_block: cover property (tick && pk[1] && !r.pickPrev[1] && bk);
   c_rec_full: cover property (r.recCnt == 4'(`TBE_NREC) && $rose(r.wrPtr == 4'h0));
   c_forced: cover property (tick && fe && r.forceSel == tbe_pkg::COND_START);
endmodule

// >>> tb/tbe_far_model.sv
// stands in for the blocking matrix and the protection functions
module tbe_far_model #(
   parameter int unsigned LEAD = 25
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       blkReq,
   input  wire logic [3:0] pickReq,
   input  wire logic [7:0] fsReq,
   input  wire logic [7:0] ftReq,
   output logic            blockIn,
   output logic      [3:0] pickUp,
   output logic      [7:0] funcStart,
   output logic      [7:0] funcTrip
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned blkAge;
   // block leads pick-up: a pick-up change waits until the block level is LEAD cycles old
   // more than one program cycle, so a late block can never race the decision
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         blockIn   <= 1'b0;
         pickUp    <= 4'h0;
         funcStart <= 8'h00;
         funcTrip  <= 8'h00;
         blkAge    <= 0;
      end else begin
         blockIn   <= blkReq;
         blkAge    <= (blkReq != blockIn) ? 0 : blkAge + 1;
         if (blkReq == blockIn && blkAge >= LEAD)
            pickUp <= pickReq;
         funcStart <= fsReq;
         funcTrip  <= ftReq;
      end
   end
endmodule

// >>> tb/tbe_trip_event_test.sv
`include "tbe_map.svh"
module tbe_trip_event_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, blockIn, blkReq;
   logic        extraStart, extraTrip, forceEnable, comStart, comTrip, evtValid, er;
   logic [7:0]  paddr, funcStart, funcTrip, fsReq, ftReq;
   logic [31:0] pwdata, prdata, evtTime, v;
   logic [3:0]  pickUp, pickReq, zoneTrip, zoneBlocked;
   logic [17:0] sv;
   logic [2:0]  settingGroup;
   logic [1:0]  condition;
   logic [5:0]  evtCode;
   logic [5:0]  evq[$];
   logic [31:0] etq[$];
   int          miscompares, n_tests, k;
   logic [1:0]  frc[3] = '{2'h3, 2'h1, 2'h0};
   logic [1:0]  frcOut[3] = '{2'h3, 2'h2, 2'h0};

   tbe_far_model far (.clk(clk), .rstn(rstn), .blkReq(blkReq), .pickReq(pickReq),
      .fsReq(fsReq), .ftReq(ftReq), .blockIn(blockIn), .pickUp(pickUp),
      .funcStart(funcStart), .funcTrip(funcTrip));
   tbe_trip_event #(.PROG_CYCLES(20)) dut (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .blockIn(blockIn), .pickUp(pickUp),
      .phStartIn(sv[0]), .phBlkIn(sv[1]), .resStartIn(sv[2]), .resBlkIn(sv[3]),
      .lightIn(sv[7:4]), .pressIn(sv[11:8]), .digitalInput(sv[12]), .sensFault(sv[16:13]),
      .ioFault(sv[17]), .funcStart(funcStart), .funcTrip(funcTrip), .extraStart(extraStart),
      .extraTrip(extraTrip), .forceEnable(forceEnable), .settingGroup(settingGroup),
      .phA(16'h1111), .phB(16'h2222), .phC(16'h3333), .resCur(16'h0444),
      .zoneTrip(zoneTrip), .zoneBlocked(zoneBlocked), .comStart(comStart), .comTrip(comTrip),
      .condition(condition), .evtValid(evtValid), .evtCode(evtCode), .evtTime(evtTime));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // event stream collector, one entry per pulse
   always @(posedge clk) begin
      if (evtValid === 1'b1) begin
         evq.push_back(evtCode);
         etq.push_back(evtTime);
      end
   end

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // apb master; holds the request until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         miscompares++;
         close_out;
      end
      v = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, v, exp);
   endtask
   // settle covers the pin sync, the model's lead and two program ticks
   task settle(input logic [5:0] code);
      evq.delete();
      etq.delete();
      repeat (80) @(posedge clk);
      chk("evtCount", evq.size(), (code === 6'h3f) ? 0 : 1);
      if (code !== 6'h3f) chk("evtCode", {26'h0, evq[0]}, {26'h0, code});
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, blkReq, pickReq, fsReq, ftReq} = '0;
      {sv, extraStart, extraTrip, forceEnable, miscompares, n_tests} = '0;
      settingGroup = 3'h2;
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc("funcen", `TBE_OFS_FUNCEN, 32'hff);
      rdc("onmask", `TBE_OFS_ONMASK, 32'hfffffff);
      rdc("offmask", `TBE_OFS_OFFMASK, 32'hfffffff);
      rdc("arccnt", `TBE_OFS_ARCCNT, 32'h0);
      rdc("status", `TBE_OFS_STATUS, 32'h0);
      rdc("unmapped", 8'h38, 32'h0);
      chk("pslverr", er, 1'b1);
      // every arc input status, ids 8 to 25, gives ON then OFF with its id
      for (k = 0; k < 18; k++) begin
         sv[k] <= 1'b1;
         settle({1'b1, 5'(8 + k)});
         sv[k] <= 1'b0;
         settle({1'b0, 5'(8 + k)});
      end
      sv[7:4] <= 4'h5;
      evq.delete();
      repeat (80) @(posedge clk);
      chk("lightEvts", evq.size(), 2);
      chk("lightFirst", {26'h0, evq[0]}, 32'h2c);
      chk("lightNext", {26'h0, evq[1]}, 32'h2e);
      apb(1'b1, `TBE_OFS_CTRL, 32'h9);
      rdc("arcClr", `TBE_OFS_ARCCNT, 32'h0);
      pickReq <= 4'h1;
      settle(6'h20);
      chk("zoneTrip", zoneTrip, 4'h1);
      rdc("arc_stage_instance_one", `TBE_OFS_ARCCNT, 32'h1);
      rdc("recTime", `TBE_OFS_RECTIME, etq[0]);
      rdc("recEvt", `TBE_OFS_RECEVT, {19'h0, 3'h2, 4'h5, 6'h20});
      rdc("recAB", `TBE_OFS_RECAB, 32'h22221111);
      rdc("recCR", `TBE_OFS_RECCR, 32'h04443333);
      pickReq <= 4'h0;
      settle(6'h00);
      apb(1'b1, `TBE_OFS_OFFMASK, 32'hffffffe);
      pickReq <= 4'h1;
      settle(6'h20);
      pickReq <= 4'h0;
      settle(6'h3f);
      blkReq <= 1'b1;
      pickReq <= 4'h2;
      settle(6'h25);
      chk("blocked", {zoneBlocked, zoneTrip}, 8'h20);
      apb(1'b0, `TBE_OFS_STATUS, 32'h0);
      chk("smpBlock", v[2], 1'b1);
      chk("recCnt", v[15:12], 4'h3);
      for (k = 0; k < 20; k++) begin
         pickReq <= pickReq ^ 4'h2;
         repeat (80) @(posedge clk);
      end
      apb(1'b0, `TBE_OFS_STATUS, 32'h0);
      chk("recFull", v[15:12], 4'hc);
      apb(1'b1, `TBE_OFS_RECSEL, 32'hc);
      rdc("recOut", `TBE_OFS_RECEVT, 32'h0);
      fsReq <= 8'h01;
      ftReq <= 8'h02;
      settingGroup <= 3'h5;
      repeat (80) @(posedge clk);
      chk("common", {comStart, comTrip, condition}, 4'hf);
      rdc("stcnt", `TBE_OFS_STCNT, 32'h1);
      rdc("trcnt", `TBE_OFS_TRCNT, 32'h1);
      apb(1'b1, `TBE_OFS_FUNCEN, 32'hfc);
      evq.delete();
      repeat (80) @(posedge clk);
      chk("offEvts", evq.size(), 2);
      chk("startOff", {26'h0, evq[0]}, 32'h1a);
      chk("tripOff", {26'h0, evq[1]}, 32'h1b);
      chk("masked", {comStart, comTrip, condition}, 4'h0);
      extraStart <= 1'b1;
      settle(6'h3a);
      extraTrip <= 1'b1;
      settle(6'h3b);
      {extraStart, extraTrip} <= 2'h0;
      repeat (80) @(posedge clk);
      apb(1'b1, `TBE_OFS_CTRL, 32'h6);
      settle(6'h3f);
      chk("noForce", {comStart, comTrip}, 2'h0);
      forceEnable <= 1'b1;
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `TBE_OFS_CTRL, {29'h0, frc[k], 1'b0});
         repeat (80) @(posedge clk);
         chk("forced", {comStart, comTrip}, frcOut[k]);
      end
      apb(1'b1, `TBE_OFS_CTRL, 32'h1);
      rdc("stClr", `TBE_OFS_STCNT, 32'h0);
      close_out;
   end
endmodule
